// ### rtl/mit_timer.v
// Multichannel down-counting interrupt timer, four channels, no register bus.
// Configuration arrives on plain ports from logic on clk; trigger pins are
// asynchronous and are synchronised before use.
//
// How it works
// - Single 32-bit mode loads the period and decrements the full counter to zero.
// - Split mode counts the lower 16 bits to zero, then the upper half.
// - Split mode raises pre-trigger when the lower half reaches zero.
// - Split mode drops pre-trigger and sets the timeout flag when upper expires.
// - Trigger count mode loads on the first trigger, then decrements per trigger.
// - Capture mode counts down from all ones; triggers store the inverted count.
// - Each channel picks one of sixteen trigger sources, numbered 0 to 15.
// - Each channel chooses external pin or internal channel trigger as origin.
// - On reaching zero a running channel flags an interrupt and reloads its period, or all ones in capture mode.
// - A new period applies only at the next reload, never restarting the count.
// - A started channel loads, counts down, then pulses its trigger and flags timeout.
// - Each channel's live count is readable, between zero and the period, or up to all ones in capture mode.
// - Software reset clears all channels and flags but not module control.
// - A chain option links a channel's counting to the previous channel.
// - Reload-on-trigger reloads the counter on each trigger; otherwise triggers don't.
// - Stop-on-timeout halts the channel after timeout; otherwise it keeps running.
// - Start-on-trigger waits for a trigger before counting; otherwise counts at once.
// - Run-during-debug decides whether timers count while the processor is in debug.
// - Run-during-doze decides whether timers count while the system dozes.
// - Each channel has a timeout flag and interrupt enable; request needs both.
`timescale 1ns/1ps
`default_nettype none
`include "mit_map.vh"

module mit_timer (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Module control, kept across software reset
    input wire moduleEnable,
    input wire runDuringDebug,
    input wire runDuringDoze,
    // System power and debug state
    input wire debugMode,
    input wire dozeMode,
    // Module software reset, one pulse
    input wire swReset,
    // Per-channel configuration, channel n in bits of slice n
    input wire [3:0] chanEnable,
    input wire [7:0] chanMode,
    input wire [3:0] chainToPrevious,
    input wire [3:0] reloadOnTrigger,
    input wire [3:0] stopOnTimeout,
    input wire [3:0] startOnTrigger,
    input wire [15:0] triggerChoice,
    input wire [3:0] triggerOrigin,
    input wire [127:0] periodLoadValue,
    // Interrupt enables and write-one-to-clear strobes for the flags
    input wire [3:0] intEnable,
    input wire [3:0] flagClear,
    // External trigger pins
    input wire [15:0] extTrigger,
    // Channel status
    output wire [127:0] currentCount,
    output wire [127:0] captureValue,
    output wire [3:0] timeoutFlag,
    output wire [3:0] preTrigger,
    output wire [3:0] triggerPulse,
    // Interrupt requests
    output wire [3:0] irqChannel,
    output wire irqAny
);

    // ========================================
    // Shared signals

    wire [15:0] extEdge;
    wire [15:0] intTrig;
    wire [3:0] chainIn;
    wire runAllowed;
    wire chanRst;

    // Counting stops in debug or doze unless the matching run bit is set
    assign runAllowed = moduleEnable
        & (runDuringDebug | ~debugMode)
        & (runDuringDoze | ~dozeMode);

    // Software reset hits channel state only; control ports are untouched
    assign chanRst = srst | swReset;

    // Internal trigger sources beyond the built channels read as idle
    assign intTrig = {12'h000, triggerPulse};

    // Channel 0 has no predecessor, so its chain input stays low
    assign chainIn = {triggerPulse[2:0], 1'b0};

    // ========================================
    // Pin synchronisers for the external trigger inputs

    genvar s;
    generate
        for (s = 0; s < `MIT_NSRC; s = s + 1) begin : gSync
            mit_sync_edge uSync (
                .clk(clk),
                .srst(srst),
                .pinIn(extTrigger[s]),
                .level(),
                .rise(extEdge[s])
            );
        end
    endgenerate

    // ========================================
    // Timer channels

    genvar g;
    generate
        for (g = 0; g < `MIT_NCHAN; g = g + 1) begin : gChan

            wire [1:0] mode;
            wire [3:0] sel;
            wire [31:0] period;
            wire [31:0] loadVal;
            wire chOn;
            wire enEdge;
            wire trigHit;
            wire trigSeen;
            wire tick;
            wire cntZero;
            wire lowZero;

            reg [31:0] cnt_r;
            reg [31:0] capture_r;
            reg chOnD_r;
            reg active_r;
            reg loaded_r;
            reg preTrig_r;
            reg flag_r;
            reg pulse_r;

            assign mode = chanMode[2*g+1:2*g];
            assign sel = triggerChoice[4*g+3:4*g];
            assign period = periodLoadValue[32*g+31:32*g];

            // Capture mode always starts from all ones; others take the period
            assign loadVal = (mode == `MIT_MODE_CAPTURE) ? `MIT_CNT_ONES : period;

            assign chOn = moduleEnable & chanEnable[g];
            assign enEdge = chOn & ~chOnD_r;

            // Source index picks the channel; origin picks pin or internal
            assign trigHit = (triggerOrigin[g] == `MIT_ORIGIN_INT) ?
                intTrig[sel] : extEdge[sel];
            assign trigSeen = chOn & runAllowed & trigHit;

            // A chained channel advances only when its predecessor expires
            assign tick = runAllowed & active_r
                & (chainToPrevious[g] ? chainIn[g] : 1'b1);

            assign cntZero = (cnt_r == `MIT_CNT_RST);
            assign lowZero = (cnt_r[15:0] == `MIT_HALF_ZERO);

            // Counter, start, reload and expiry handling
            always @(posedge clk) begin
                if (chanRst) begin
                    cnt_r <= `MIT_CNT_RST;
                    capture_r <= `MIT_CNT_RST;
                    chOnD_r <= 1'b0;
                    active_r <= 1'b0;
                    loaded_r <= 1'b0;
                    preTrig_r <= 1'b0;
                    flag_r <= 1'b0;
                    pulse_r <= 1'b0;
                end else begin
                    chOnD_r <= chOn;
                    pulse_r <= 1'b0;
                    // Clear first so a same-cycle expiry below wins
                    if (flagClear[g]) begin
                        flag_r <= 1'b0;
                    end
                    if (!chOn) begin
                        // Disabled channel holds its count and waits
                        active_r <= 1'b0;
                        loaded_r <= 1'b0;
                        preTrig_r <= 1'b0;
                    end else if (enEdge) begin
                        // Start: load, then run now or wait for a trigger
                        cnt_r <= loadVal;
                        active_r <= ~startOnTrigger[g];
                        loaded_r <= 1'b0;
                        preTrig_r <= 1'b0;
                    end else if (mode == `MIT_MODE_TRIGCNT) begin
                        // Trigger count: the clock plays no part here
                        if (trigSeen) begin
                            if (!loaded_r) begin
                                cnt_r <= period;
                                loaded_r <= 1'b1;
                            end else if (cntZero) begin
                                cnt_r <= period;
                                flag_r <= 1'b1;
                                pulse_r <= 1'b1;
                            end else begin
                                cnt_r <= cnt_r - 32'h00000001;
                            end
                        end
                    end else begin
                        // Capture snapshot does not disturb the count
                        if (trigSeen && mode == `MIT_MODE_CAPTURE) begin
                            capture_r <= ~cnt_r;
                        end
                        if (trigSeen && startOnTrigger[g] && !active_r) begin
                            active_r <= 1'b1;
                            cnt_r <= loadVal;
                            preTrig_r <= 1'b0;
                        end else if (trigSeen && reloadOnTrigger[g]) begin
                            cnt_r <= loadVal;
                            preTrig_r <= 1'b0;
                        end else if (tick) begin
                            if (cntZero) begin
                                // Expiry: period sampled here, so late writes wait
                                cnt_r <= loadVal;
                                flag_r <= 1'b1;
                                pulse_r <= 1'b1;
                                preTrig_r <= 1'b0;
                                if (stopOnTimeout[g]) begin
                                    active_r <= 1'b0;
                                end
                            end else if (mode == `MIT_MODE_SPLIT16) begin
                                if (!lowZero) begin
                                    cnt_r[15:0] <= cnt_r[15:0] - `MIT_HALF_ONE;
                                    if (cnt_r[15:0] == `MIT_HALF_ONE) begin
                                        preTrig_r <= 1'b1;
                                    end
                                end else begin
                                    preTrig_r <= 1'b1;
                                    cnt_r[31:16] <= cnt_r[31:16] - `MIT_HALF_ONE;
                                end
                            end else begin
                                cnt_r <= cnt_r - 32'h00000001;
                            end
                        end
                    end
                end
            end

            // Status outputs straight from flip-flops
            assign currentCount[32*g+31:32*g] = cnt_r;
            assign captureValue[32*g+31:32*g] = capture_r;
            assign timeoutFlag[g] = flag_r;
            assign preTrigger[g] = preTrig_r;
            assign triggerPulse[g] = pulse_r;

            // Request only while both flag and enable are set
            assign irqChannel[g] = flag_r & intEnable[g];
        end
    endgenerate

    // ========================================
    // Combined interrupt request
    assign irqAny = |irqChannel;

endmodule // mit_timer

`default_nettype wire

// ### rtl/mit_map.vh
// Constants of the multichannel interrupt timer: modes, sizes, reset values.
// Included by the timer top module only; the synchroniser does not use it. Holds definitions only.
`ifndef MIT_MAP_VH
`define MIT_MAP_VH

// Number of timer channels and of selectable trigger sources
`define MIT_NCHAN 4
`define MIT_NSRC 16
`define MIT_SEL_W 4

// Counter width and the halves used in split mode
`define MIT_CNT_W 32
`define MIT_HALF_W 16

// Channel operating modes (two-bit field per channel)
`define MIT_MODE_SINGLE32 2'h0
`define MIT_MODE_SPLIT16 2'h1
`define MIT_MODE_TRIGCNT 2'h2
`define MIT_MODE_CAPTURE 2'h3

// Trigger origin encoding
`define MIT_ORIGIN_EXT 1'h0
`define MIT_ORIGIN_INT 1'h1

// Reset and load values
`define MIT_CNT_RST 32'h00000000
`define MIT_CNT_ONES 32'hffffffff
`define MIT_HALF_ZERO 16'h0000
`define MIT_HALF_ONE 16'h0001

// Settling time software allows after toggling the module enable
`define MIT_EN_SETTLE_CYC 4

`endif

// ### rtl/mit_sync_edge.v
// Two-flop synchroniser with rising-edge detector for one pin input.
// Assumes the pin is asynchronous to clk; the pulse is one clk cycle wide.
`timescale 1ns/1ps
`default_nettype none

module mit_sync_edge (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Pin side
    input wire pinIn,
    // Logic side
    output wire level,
    output wire rise
);

    reg meta_r;
    reg sync_r;
    reg last_r;

    // ========================================
    // Synchroniser: meta_r feeds sync_r and nothing else
    always @(posedge clk) begin
        if (srst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pinIn;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise = sync_r & ~last_r; // One pulse per rising edge

endmodule // mit_sync_edge

`default_nettype wire

// ### tb/mit_timer_sva.sv
// Checker for the multichannel timer, watching only the top module's ports.
// Assumes the bench keeps reloadOnTrigger low on channel 0 and period above 1.
`timescale 1ns/1ps
`default_nettype none

module mit_timer_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    input wire logic swReset,
    // Controls
    input wire logic moduleEnable,
    input wire logic runDuringDebug,
    input wire logic runDuringDoze,
    input wire logic debugMode,
    input wire logic dozeMode,
    input wire logic [3:0] chanEnable,
    input wire logic [7:0] chanMode,
    input wire logic [3:0] reloadOnTrigger,
    input wire logic [127:0] periodLoadValue,
    input wire logic [3:0] intEnable,
    input wire logic [3:0] flagClear,
    // Status
    input wire logic [127:0] currentCount,
    input wire logic [3:0] timeoutFlag,
    input wire logic [3:0] preTrigger,
    input wire logic [3:0] triggerPulse,
    input wire logic [3:0] irqChannel,
    input wire logic irqAny
);
    // ==========================================
    // Helpers
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Timers frozen by debug or doze
    wire logic halted = (debugMode & ~runDuringDebug) | (dozeMode & ~runDuringDoze);
    wire logic run0 = moduleEnable & chanEnable[0];

    // ==========================================
    // Properties
    sequence s_exp0;
        triggerPulse[0] && chanMode[1:0] == 2'h0;
    endsequence
    property p_irq_map; irqChannel == (timeoutFlag & intEnable); endproperty
    a_irq_map: assert property (p_irq_map) else $error("irq map wrong");
    property p_irq_any; irqAny == |irqChannel; endproperty
    a_irq_any: assert property (p_irq_any) else $error("irqAny wrong");
    property p_reload;
        s_exp0 |-> timeoutFlag[0] && currentCount[31:0] == $past(periodLoadValue[31:0]);
    endproperty
    a_reload: assert property (p_reload) else $error("reload wrong");
    property p_flag_hold; timeoutFlag[0] && !flagClear[0] && !swReset |=> timeoutFlag[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
    property p_flag_clr; flagClear[0] && !swReset |=> !timeoutFlag[0] || triggerPulse[0];
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag kept");
    property p_soft_reset;
        swReset |=> currentCount == 128'h0 && timeoutFlag == 4'h0 && preTrigger == 4'h0;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset");
    // Previous-cycle terms keep a fresh start out of the frozen check
    property p_halt;
        halted && run0 && $past(run0) && !$past(srst) && !$past(swReset) && !swReset
            && !reloadOnTrigger[0] && chanMode[1:0] == 2'h0 |=> $stable(currentCount[31:0]);
    endproperty
    a_halt: assert property (p_halt) else $error("count moved");
    property p_pre_rise; $rose(preTrigger[1]) |-> currentCount[47:32] == 16'h0000;
    endproperty
    a_pre_rise: assert property (p_pre_rise) else $error("pre early");
    property p_pre_drop; triggerPulse[1] && chanMode[3:2] == 2'h1 |-> !preTrigger[1];
    endproperty
    a_pre_drop: assert property (p_pre_drop) else $error("pre stuck");
endmodule // mit_timer_sva

bind mit_timer mit_timer_sva i_sva (.clk, .srst, .swReset, .moduleEnable, .runDuringDebug,
    .runDuringDoze, .debugMode, .dozeMode, .chanEnable, .chanMode, .reloadOnTrigger,
    .periodLoadValue, .intEnable, .flagClear, .currentCount, .timeoutFlag, .preTrigger,
    .triggerPulse, .irqChannel, .irqAny);
`default_nettype wire

// ### tb/tb_mit_timer.sv
// Self-checking bench for the multichannel timer, driving its ports directly.
// Assumes a 10 MHz clock; inputs change 10 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none

module tb_mit_timer;
    // ==========================================
    // Stimulus and observed signals
    logic clk = 0, srst = 1, swReset = 0, moduleEnable = 0, runDuringDebug = 0;
    logic runDuringDoze = 0, debugMode = 0, dozeMode = 0;
    logic [3:0] chanEnable = 0, chainToPrevious = 0, reloadOnTrigger = 0, stopOnTimeout = 0;
    logic [3:0] startOnTrigger = 0, triggerOrigin = 0, intEnable = 0, flagClear = 0;
    logic [7:0] chanMode = 0;
    logic [15:0] triggerChoice = 0, extTrigger = 0;
    logic [127:0] periodLoadValue = 0;
    wire [127:0] currentCount, captureValue;
    wire [3:0] timeoutFlag, preTrigger, triggerPulse, irqChannel;
    wire irqAny;
    logic [31:0] c;
    int numErrors = 0, nTests = 0;

    mit_timer i_dut (.clk, .srst, .moduleEnable, .runDuringDebug, .runDuringDoze, .debugMode,
        .dozeMode, .swReset, .chanEnable, .chanMode, .chainToPrevious, .reloadOnTrigger,
        .stopOnTimeout, .startOnTrigger, .triggerChoice, .triggerOrigin, .periodLoadValue,
        .intEnable, .flagClear, .extTrigger, .currentCount, .captureValue, .timeoutFlag,
        .preTrigger, .triggerPulse, .irqChannel, .irqAny);

    // Clock, 100 ns period
    always #50 clk = ~clk;

    // ==========================================
    // Tasks
    task step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            numErrors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bounded wait for a channel 1 expiry; a hang counts as a mismatch
    task wt;
        int i;
        i = 0;
        while (triggerPulse[1] !== 1'b1 && i < 50) begin
            step(1);
            i++;
        end
        chk(i < 50, 32'h1);
    endtask
    task tallyAndFinish;
        $display("comparisons %0d mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Watchdog: the sequence needs well under 1000 cycles
    initial begin
        #300000;
        numErrors++;
        tallyAndFinish;
    end

    // ==========================================
    // Main sequence
    initial begin
        step(20);
        srst = 0;
        // Channel 0 single 32-bit, period 2, walked cycle by cycle
        periodLoadValue[31:0] = 32'h2;
        intEnable = 4'h1;
        moduleEnable = 1;
        step(5);
        chanEnable = 4'h1;
        step(1); chk(currentCount[31:0], 32'h2);
        step(1); chk(currentCount[31:0], 32'h1);
        step(1); chk(currentCount[31:0], 32'h0);
        step(1); chk({irqAny, timeoutFlag[0], triggerPulse[0], currentCount[28:0]}, 32'he0000002);
        // New period mid-run must wait for the next expiry
        periodLoadValue[31:0] = 32'hc8;
        step(1); chk(currentCount[31:0], 32'h1);
        step(2); chk(currentCount[31:0], 32'hc8);
        intEnable = 4'h0;
        step(5); chk({irqAny, irqChannel[0], timeoutFlag[0]}, 32'h1);
        flagClear = 4'h1;
        step(1); chk(timeoutFlag[0], 32'h0);
        flagClear = 4'h0;
        // Debug then doze: frozen with neither run bit set, counting again once both run bits are set
        for (int k = 0; k < 2; k++) begin
            {dozeMode, debugMode} = k ? 2'h2 : 2'h1;
            step(1); c = currentCount[31:0];
            step(5); chk(currentCount[31:0], c);
            {runDuringDoze, runDuringDebug} = 2'h3;
            step(5); chk(currentCount[31:0], c - 32'h5);
            {runDuringDoze, runDuringDebug, dozeMode, debugMode} = 4'h0;
        end
        // Channel 1 split mode: low half first, pre-trigger, then high half
        chanMode[3:2] = 2'h1;
        periodLoadValue[63:32] = 32'h00020003;
        chanEnable[1] = 1;
        step(1); chk(currentCount[63:32], 32'h00020003);
        step(3); chk({preTrigger[1], currentCount[62:32]}, 32'h80020000);
        step(2); chk({preTrigger[1], currentCount[62:32]}, 32'h80000000);
        step(1); chk({timeoutFlag[1], preTrigger[1], triggerPulse[1]}, 32'h5);
        // Channel 2 capture from external pin 5
        chanMode[5:4] = 2'h3;
        triggerChoice[11:8] = 4'h5;
        chanEnable[2] = 1;
        step(1); chk(currentCount[95:64], 32'hffffffff);
        step(10); extTrigger[5] = 1;
        step(6); chk(captureValue[95:64], 32'hc);
        // Channel 3 counts channel 1 expiries through the internal origin
        chanMode[7:6] = 2'h2;
        triggerOrigin[3] = 1;
        triggerChoice[15:12] = 4'h1;
        periodLoadValue[127:96] = 32'ha;
        chanEnable[3] = 1;
        wt; step(2); chk(currentCount[127:96], 32'ha);
        wt; step(2); chk(currentCount[127:96], 32'h9);
        // Software reset clears the channel 0 and 1 counts and every flag
        swReset = 1;
        step(1); chk(currentCount[31:0] | currentCount[63:32] | {28'h0, timeoutFlag}, 32'h0);
        swReset = 0;
        step(2);
        // Chain, stop-on-timeout, start-on-trigger and reload-on-trigger
        chanEnable = 4'h0;
        step(1);
        chanMode = 8'h00;
        triggerOrigin = 4'h0;
        extTrigger = 16'h0000;
        chainToPrevious = 4'h2;
        stopOnTimeout = 4'h1;
        startOnTrigger = 4'h4;
        reloadOnTrigger = 4'h4;
        periodLoadValue[31:0] = 32'h3;
        periodLoadValue[63:32] = 32'h2;
        periodLoadValue[95:64] = 32'h64;
        chanEnable = 4'h7;
        step(6); chk(currentCount[63:32], 32'h1);
        step(3); chk({timeoutFlag[0], currentCount[30:0]}, 32'h80000003);
        chk(currentCount[63:32], 32'h1);
        chk(currentCount[95:64], 32'h64);
        extTrigger[5] = 1;
        step(4); chk(currentCount[95:64], 32'h63);
        extTrigger[5] = 0;
        step(5); chk(currentCount[95:64], 32'h5e);
        extTrigger[5] = 1;
        step(3); chk(currentCount[95:64], 32'h64);
        step(2);
        tallyAndFinish;
    end
endmodule // tb_mit_timer
`default_nettype wire
